/* File: hw/clk_gate_pkg.sv */
// Purpose: Shared constants for the slow bus clock gates and backup domain control.
// Assumes: Byte addressed register port, 32-bit data, 25 MHz mclk.
// Notes: Offsets are byte addresses; field positions index the 32-bit word.
package clk_gate_pkg;
    // Register offsets
    localparam logic [7:0] GATES_OFFSET = 8'h1C;
    localparam logic [7:0] BACKUP_OFFSET = 8'h20;
    localparam logic [31:0] GATES_RESET = 32'h0000_0000;
    localparam logic [31:0] BACKUP_RESET = 32'h0000_0000;

    // Clock gate bit positions
    localparam int TIMER_TWO_BIT = 0;
    localparam int TIMER_THREE_BIT = 1;
    localparam int TIMER_FOUR_BIT = 2;
    localparam int WINDOW_DOG_BIT = 11;
    localparam int SECOND_SPI_BIT = 14;
    localparam int SECOND_SERIAL_BIT = 17;
    localparam int THIRD_SERIAL_BIT = 18;
    localparam int I2C_PORT_A_BIT = 21;
    localparam int I2C_PORT_B_BIT = 22;
    localparam int USB_DEVICE_BIT = 23;
    localparam int CAN_BIT = 25;
    localparam int BACKUP_IF_BIT = 27;
    localparam int POWER_UNIT_IF_BIT = 28;
    // Implemented gate bits; all others read as zero
    localparam logic [31:0] GATES_MASK = 32'h1AE6_4807;

    // Backup domain control field positions
    localparam int OSC_ON_BIT = 0;
    localparam int OSC_STABLE_BIT = 1;
    localparam int OSC_BYPASS_BIT = 2;
    localparam int RTC_SEL_LSB = 8;
    localparam int RTC_ON_BIT = 15;
    localparam int SOFT_RESET_BIT = 16;

    // Real-time clock source codes
    localparam logic [1:0] RTC_SRC_NONE = 2'h0;
    localparam logic [1:0] RTC_SRC_SLOW_EXT = 2'h1;
    localparam logic [1:0] RTC_SRC_SLOW_INT = 2'h2;
    localparam logic [1:0] RTC_SRC_FAST_EXT = 2'h3;
    localparam int RTC_FAST_DIVIDE = 128;

    // Timing
    localparam int MCLK_PERIOD_NS = 40;
    localparam int SLOW_TICK_GAP_NS = 100000;
    localparam int SLOW_TICK_GAP_CYCLES = SLOW_TICK_GAP_NS / MCLK_PERIOD_NS;
    localparam int SLOW_OSC_SETTLE_TICKS = 16;
endpackage

/* File: hw/slow_osc_monitor.sv */
// Purpose: Decides whether the slow external oscillator is running steadily.
// Assumes: slow_tick is a one-cycle pulse per oscillator period, synchronous to mclk.
// Notes: Stable after SETTLE_TICKS ticks; a gap longer than GAP_CYCLES drops it.
`timescale 1ns/1ps
`default_nettype none
module slow_osc_monitor import clk_gate_pkg::*; #(
    parameter int SETTLE_TICKS = SLOW_OSC_SETTLE_TICKS,
    parameter int GAP_CYCLES = SLOW_TICK_GAP_CYCLES
) (
    input wire logic mclk,
    input wire logic clear,
    input wire logic osc_on,
    input wire logic slow_tick,
    output logic stable
);
    typedef struct packed {
        logic [7:0] ticks;
        logic [15:0] gap;
        logic stable;
    } mon_s;

    mon_s st;
    mon_s next_st;

    // Refuse settings the counters cannot hold
    if (SETTLE_TICKS < 1 || SETTLE_TICKS > 255 || GAP_CYCLES < 2 || GAP_CYCLES > 65535) begin : g_chk
        $error("slow_osc_monitor: parameter out of range");
    end

    // Count ticks toward stable, watch for a missing tick
    always_comb begin
        next_st = st;
        if (clear || !osc_on) begin
            next_st = '0;
        end else if (slow_tick) begin
            next_st.gap = '0;
            if (st.ticks != 8'(SETTLE_TICKS)) begin
                next_st.ticks = st.ticks + 8'h01;
            end
            next_st.stable = (st.ticks >= 8'(SETTLE_TICKS - 1));
        end else if (st.gap == 16'(GAP_CYCLES - 1)) begin
            next_st = '0; // Oscillator lost
        end else begin
            next_st.gap = st.gap + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign stable = st.stable;
endmodule
`default_nettype wire

/* File: hw/rtc_source_mux.sv */
// Purpose: Picks the real-time clock source and divides the fast one by 128.
// Assumes: Source clocks arrive as one-cycle tick pulses on mclk.
// Notes: rtc_tick is a registered one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module rtc_source_mux import clk_gate_pkg::*; #(
    parameter int DIVIDE = RTC_FAST_DIVIDE
) (
    input wire logic mclk,
    input wire logic clear,
    input wire logic [1:0] source,
    input wire logic enable,
    input wire logic slow_ext_tick,
    input wire logic slow_int_tick,
    input wire logic fast_ext_tick,
    output logic rtc_tick
);
    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } mux_s;

    mux_s st;
    mux_s next_st;
    logic div_pulse;

    if (DIVIDE < 2 || DIVIDE > 256) begin : g_chk
        $error("rtc_source_mux: DIVIDE out of range");
    end

    assign div_pulse = fast_ext_tick && (st.count == 8'(DIVIDE - 1));

    // Divide fast ticks, then select the source
    always_comb begin
        next_st = st;
        if (fast_ext_tick) begin
            next_st.count = div_pulse ? 8'h00 : st.count + 8'h01;
        end
        case (source)
            RTC_SRC_SLOW_EXT: next_st.tick = enable && slow_ext_tick;
            RTC_SRC_SLOW_INT: next_st.tick = enable && slow_int_tick;
            RTC_SRC_FAST_EXT: next_st.tick = enable && div_pulse;
            default: next_st.tick = 1'b0;
        endcase
        if (clear) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign rtc_tick = st.tick;
endmodule
`default_nettype wire

/* File: hw/slow_bus_clock_ctrl.sv */
// Purpose: Slow bus clock gate register and backup domain control register.
// Assumes: Register port with byte enables; read data one cycle after the read strobe.
// Notes: The backup register only answers to backup_resetn and its own soft reset.
//
// Summary of operation
// R01: Gate register at 0x1C, resets to zero
// R02: Word, half word and byte access accepted
// R03: No wait, except during slow peripheral access
// R04: Gated peripheral reads return zero
// R05: Gate bits read/write, held until changed
// R06: Bits 0-2 gate timers two to four
// R07: Bit 11 gates window watchdog
// R08: Bits 14,17,18 gate SPI and serials
// R09: Bits 21-23,25 gate I2C, USB, CAN
// R10: Bit 27 gates backup interface
// R11: Bit 28 gates power unit; rest reserved
// R12: Backup register at 0x20, backup reset only
// R13: Wait on back-to-back backup register accesses
// R14: Backup fields writable only when unlocked; bit 16 soft reset here is written without the unlock
// R15: Bit 0 switches slow oscillator on
// R16: Bit 1 shows oscillator stable, read only
// R17: Bit 2 selects bypass of crystal
// R18: Bits 9:8 select real-time clock source
// R19: Source 11 is fast clock over 128
// R20: Source change needs backup domain reset first
// R21: Bit 15 enables the real-time clock
// R22: Writing bit 16 resets backup domain
// R23: Reset held while bit 16 stays set
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module slow_bus_clock_ctrl import clk_gate_pkg::*; #(
    parameter int SETTLE_TICKS = SLOW_OSC_SETTLE_TICKS,
    parameter int GAP_CYCLES = SLOW_TICK_GAP_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic backup_resetn,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [3:0] bus_byte_en,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata,
    output logic bus_wait,
    // Power unit unlock
    input wire logic backup_write_unlock,
    // Slow peripheral bus read path
    input wire logic [31:0] periph_select,
    input wire logic periph_start,
    input wire logic periph_done,
    input wire logic [31:0] periph_rdata,
    output logic [31:0] periph_rdata_gated,
    output logic periph_wait,
    // Clock gates
    output logic timer_two_clk_en,
    output logic timer_three_clk_en,
    output logic timer_four_clk_en,
    output logic window_dog_clk_en,
    output logic second_spi_clk_en,
    output logic second_serial_clk_en,
    output logic third_serial_clk_en,
    output logic i2c_port_a_clk_en,
    output logic i2c_port_b_clk_en,
    output logic usb_device_clk_en,
    output logic can_clk_en,
    output logic backup_if_clk_en,
    output logic power_unit_if_clk_en,
    // Backup domain
    input wire logic slow_external_clock,
    input wire logic slow_internal_clock,
    input wire logic fast_external_clock,
    output logic slow_ext_osc_on,
    output logic slow_ext_osc_bypass,
    output logic backup_domain_reset,
    output logic rtc_tick
);
    typedef struct packed {
        logic [31:0] gates;
        logic osc_on;
        logic bypass;
        logic [1:0] rtc_sel;
        logic rtc_on;
        logic soft_rst;
        logic [31:0] rdata;
        logic [31:0] periph_q;
        logic periph_pending;
        logic bd_touched;
    } ctrl_s;

    ctrl_s st;
    ctrl_s next_st;
    logic osc_stable;
    logic bd_clear;
    logic gate_hit;
    logic bd_hit;
    logic [31:0] bd_word;
    logic [31:0] bd_new;
    logic [31:0] periph_live;

    // Apply byte enables so word, half word and byte writes all merge
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // R22: soft reset drives the whole backup domain
    assign bd_clear = !backup_resetn || st.soft_rst;

    // R02: decode any access width by word address
    assign gate_hit = (bus_addr[7:2] == GATES_OFFSET[7:2]);
    assign bd_hit = (bus_addr[7:2] == BACKUP_OFFSET[7:2]);

    // Current backup register image
    always_comb begin
        bd_word = BACKUP_RESET;
        bd_word[OSC_ON_BIT] = st.osc_on;
        // R16: stable flag straight from hardware
        bd_word[OSC_STABLE_BIT] = osc_stable;
        bd_word[OSC_BYPASS_BIT] = st.bypass;
        bd_word[RTC_SEL_LSB +: 2] = st.rtc_sel;
        bd_word[RTC_ON_BIT] = st.rtc_on;
        bd_word[SOFT_RESET_BIT] = st.soft_rst;
    end

    assign bd_new = merge_bytes(bd_word, bus_wdata, bus_byte_en);

    // R04: one-hot select picks the gate bit of the addressed peripheral
    assign periph_live = ((periph_select & st.gates & GATES_MASK) != 32'h0000_0000) ?
                         periph_rdata : 32'h0000_0000;

    // Register updates, resets and read path
    always_comb begin
        next_st = st;
        next_st.rdata = 32'h0000_0000;
        next_st.bd_touched = (bus_read || bus_write) && bd_hit;

        // R05: gate bits held until software writes them
        if (bus_write && gate_hit) begin
            next_st.gates = merge_bytes(st.gates, bus_wdata, bus_byte_en) & GATES_MASK;
        end

        if (bus_write && bd_hit) begin
            // R22: soft reset bit is not behind the unlock
            next_st.soft_rst = bd_new[SOFT_RESET_BIT];
            // R14: protected fields need the power unit unlock
            if (backup_write_unlock) begin
                // R15: oscillator on/off
                next_st.osc_on = bd_new[OSC_ON_BIT];
                // R17: bypass selection
                next_st.bypass = bd_new[OSC_BYPASS_BIT];
                // R21: real-time clock enable
                next_st.rtc_on = bd_new[RTC_ON_BIT];
                // R20: source set only from the no-clock state
                if (st.rtc_sel == RTC_SRC_NONE) begin
                    next_st.rtc_sel = bd_new[RTC_SEL_LSB +: 2];
                end
            end
        end

        // R23: domain held cleared while soft reset bit is set
        if (st.soft_rst) begin
            next_st.osc_on = 1'b0;
            next_st.bypass = 1'b0;
            next_st.rtc_sel = RTC_SRC_NONE;
            next_st.rtc_on = 1'b0;
        end

        // R03: slow peripheral access tracked until done
        if (periph_start && !periph_done) begin
            next_st.periph_pending = 1'b1;
        end else if (periph_done) begin
            next_st.periph_pending = 1'b0;
        end
        if (periph_done) begin
            next_st.periph_q = periph_live;
        end

        // Read data stands one cycle after the strobe; unmapped reads zero
        if (bus_read) begin
            if (gate_hit) begin
                // R11: reserved gate bits read zero
                next_st.rdata = st.gates & GATES_MASK;
            end else if (bd_hit) begin
                next_st.rdata = bd_word;
            end
        end

        // R12: backup register follows only the backup domain reset
        if (!backup_resetn) begin
            next_st.osc_on = 1'b0;
            next_st.bypass = 1'b0;
            next_st.rtc_sel = RTC_SRC_NONE;
            next_st.rtc_on = 1'b0;
            next_st.soft_rst = 1'b0;
        end
        // R01: system reset clears the gates and bus state
        if (!resetn) begin
            next_st.gates = GATES_RESET;
            next_st.rdata = 32'h0000_0000;
            next_st.periph_q = 32'h0000_0000;
            next_st.periph_pending = 1'b0;
            next_st.bd_touched = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    // Oscillator stability watcher
    slow_osc_monitor #(
        .SETTLE_TICKS(SETTLE_TICKS),
        .GAP_CYCLES(GAP_CYCLES)
    ) u_osc_mon (
        .mclk(mclk),
        .clear(bd_clear),
        .osc_on(st.osc_on),
        .slow_tick(slow_external_clock),
        .stable(osc_stable)
    );

    // R18: source select; R19: fast clock divided by 128
    rtc_source_mux #(
        .DIVIDE(RTC_FAST_DIVIDE)
    ) u_rtc_mux (
        .mclk(mclk),
        .clear(bd_clear),
        .source(st.rtc_sel),
        .enable(st.rtc_on),
        .slow_ext_tick(slow_external_clock && osc_stable),
        .slow_int_tick(slow_internal_clock),
        .fast_ext_tick(fast_external_clock),
        .rtc_tick(rtc_tick)
    );

    // R13: back-to-back backup register accesses flag a wait
    assign bus_wait = st.bd_touched && (bus_read || bus_write) && bd_hit;
    // R03: wait until the slow peripheral reports done
    assign periph_wait = (st.periph_pending || periph_start) && !periph_done;

    assign bus_rdata = st.rdata;
    assign periph_rdata_gated = st.periph_q;
    assign slow_ext_osc_on = st.osc_on;
    assign slow_ext_osc_bypass = st.bypass;
    assign backup_domain_reset = bd_clear;

    // R06: timer gates
    assign timer_two_clk_en = st.gates[TIMER_TWO_BIT];
    assign timer_three_clk_en = st.gates[TIMER_THREE_BIT];
    assign timer_four_clk_en = st.gates[TIMER_FOUR_BIT];
    // R07: window watchdog gate
    assign window_dog_clk_en = st.gates[WINDOW_DOG_BIT];
    // R08: SPI and serial gates
    assign second_spi_clk_en = st.gates[SECOND_SPI_BIT];
    assign second_serial_clk_en = st.gates[SECOND_SERIAL_BIT];
    assign third_serial_clk_en = st.gates[THIRD_SERIAL_BIT];
    // R09: I2C, USB and CAN gates
    assign i2c_port_a_clk_en = st.gates[I2C_PORT_A_BIT];
    assign i2c_port_b_clk_en = st.gates[I2C_PORT_B_BIT];
    assign usb_device_clk_en = st.gates[USB_DEVICE_BIT];
    assign can_clk_en = st.gates[CAN_BIT];
    // R10: backup interface gate
    assign backup_if_clk_en = st.gates[BACKUP_IF_BIT];
    // R11: power unit interface gate
    assign power_unit_if_clk_en = st.gates[POWER_UNIT_IF_BIT];
endmodule
`default_nettype wire

/* File: hw/_end.sv */
`default_nettype wire

/* File: tb/slow_bus_clock_ctrl_asserts.sv */
// Purpose: Port checks for the slow bus clock gates and backup control.
// Assumes: One mclk domain; resetn synchronous, active low.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module slow_bus_clock_ctrl_asserts import clk_gate_pkg::*; (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic backup_resetn,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [3:0] bus_byte_en,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_wait,
    input wire logic backup_write_unlock,
    input wire logic [31:0] periph_select,
    input wire logic periph_start,
    input wire logic periph_done,
    input wire logic [31:0] periph_rdata,
    input wire logic [31:0] periph_rdata_gated,
    input wire logic periph_wait,
    input wire logic timer_two_clk_en,
    input wire logic slow_ext_osc_on,
    input wire logic slow_ext_osc_bypass,
    input wire logic backup_domain_reset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Full word writes to each register and any access to the backup register
    logic gate_wr;
    logic bk_wr;
    logic bk_acc;
    assign gate_wr = bus_write && bus_addr == GATES_OFFSET && bus_byte_en == 4'hf;
    assign bk_wr = bus_write && bus_addr == BACKUP_OFFSET && bus_byte_en == 4'hf;
    assign bk_acc = (bus_write || bus_read) && bus_addr == BACKUP_OFFSET;
    property p_rdata_idle;
        !$past(bus_read) |-> bus_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_timer;
        gate_wr |=> timer_two_clk_en == $past(bus_wdata[TIMER_TWO_BIT]);
    endproperty
    a_timer: assert property (p_timer) else $error("timer two gate not written");
    property p_hold;
        resetn && !bus_write |=> $stable(timer_two_clk_en);
    endproperty
    a_hold: assert property (p_hold) else $error("gate bit changed alone");
    property p_locked;
        bk_wr && !backup_write_unlock && backup_resetn && !backup_domain_reset
            && !bus_wdata[SOFT_RESET_BIT]
            |=> $stable(slow_ext_osc_on) && $stable(slow_ext_osc_bypass);
    endproperty
    a_locked: assert property (p_locked) else $error("locked field changed");
    property p_osc_set;
        bk_wr && backup_write_unlock && backup_resetn && !backup_domain_reset
            && !bus_wdata[SOFT_RESET_BIT] |=> slow_ext_osc_on == $past(bus_wdata[0])
            && slow_ext_osc_bypass == $past(bus_wdata[2]);
    endproperty
    a_osc_set: assert property (p_osc_set) else $error("oscillator fields wrong");
    property p_soft_on;
        bk_wr && bus_wdata[SOFT_RESET_BIT] |=> backup_domain_reset;
    endproperty
    a_soft_on: assert property (p_soft_on) else $error("soft reset not raised");
    property p_soft_hold;
        backup_domain_reset && backup_resetn && !(bus_write && bus_addr == BACKUP_OFFSET)
            |=> backup_domain_reset && !slow_ext_osc_on;
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft reset not held");
    property p_periph_wait;
        periph_start && !periph_done |-> periph_wait;
    endproperty
    a_periph_wait: assert property (p_periph_wait) else $error("no wait on access");
    property p_periph_data;
        periph_done && periph_select == 32'h0000_0001 |=> periph_rdata_gated ==
            ($past(timer_two_clk_en) ? $past(periph_rdata) : 32'h0000_0000);
    endproperty
    a_periph_data: assert property (p_periph_data) else $error("gated read data wrong");
    property p_bus_wait;
        bk_acc && $past(bk_acc) |-> bus_wait;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("no wait on repeat access");
    // Main scenarios reached
    c_gate_wr: cover property (gate_wr);
    c_unlocked: cover property (bk_wr && backup_write_unlock);
    c_soft: cover property (backup_domain_reset && backup_resetn);
endmodule
bind slow_bus_clock_ctrl slow_bus_clock_ctrl_asserts chk (.mclk, .resetn, .backup_resetn,
    .bus_addr, .bus_wdata, .bus_byte_en, .bus_write, .bus_read, .bus_rdata, .bus_wait,
    .backup_write_unlock, .periph_select, .periph_start, .periph_done, .periph_rdata,
    .periph_rdata_gated, .periph_wait, .timer_two_clk_en, .slow_ext_osc_on,
    .slow_ext_osc_bypass, .backup_domain_reset);
`default_nettype wire

/* File: tb/slow_bus_clock_ctrl_tb.sv */
// Purpose: Directed bench for the slow bus clock gates and backup control.
// Assumes: Short settle (2) and gap (20) counts.
// Notes: Each scenario task judges its own results.
`timescale 1ns/1ps
`default_nettype none
module slow_bus_clock_ctrl_tb import clk_gate_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic bk_rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic unlock = 1'b0;
    logic [31:0] psel = 32'h0000_0000;
    logic [31:0] pdata = 32'h0000_0000;
    logic pstart = 1'b0;
    logic pdone = 1'b0;
    logic [2:0] tk = 3'h0;
    logic [31:0] rdata;
    logic [31:0] pgated;
    logic [12:0] en;
    logic bwait, pwait, osc_on, osc_byp, bd_rst, rtc;
    int err_total = 0;
    int n_checks = 0;
    int rtc_n = 0;
    slow_bus_clock_ctrl #(.SETTLE_TICKS(2), .GAP_CYCLES(20)) uut (.mclk(mclk),
        .resetn(resetn), .backup_resetn(bk_rstn), .bus_addr(addr), .bus_wdata(wdata),
        .bus_byte_en(be), .bus_write(wr_s), .bus_read(rd_s), .bus_rdata(rdata),
        .bus_wait(bwait), .backup_write_unlock(unlock), .periph_select(psel),
        .periph_start(pstart), .periph_done(pdone), .periph_rdata(pdata),
        .periph_rdata_gated(pgated), .periph_wait(pwait), .timer_two_clk_en(en[0]),
        .timer_three_clk_en(en[1]), .timer_four_clk_en(en[2]), .window_dog_clk_en(en[3]),
        .second_spi_clk_en(en[4]), .second_serial_clk_en(en[5]),
        .third_serial_clk_en(en[6]), .i2c_port_a_clk_en(en[7]), .i2c_port_b_clk_en(en[8]),
        .usb_device_clk_en(en[9]), .can_clk_en(en[10]), .backup_if_clk_en(en[11]),
        .power_unit_if_clk_en(en[12]), .slow_external_clock(tk[0]),
        .slow_internal_clock(tk[1]), .fast_external_clock(tk[2]), .slow_ext_osc_on(osc_on),
        .slow_ext_osc_bypass(osc_byp), .backup_domain_reset(bd_rst), .rtc_tick(rtc));
    // Clock and rtc pulse counter; counts mid-cycle so checks never race it
    always #20 mclk = ~mclk;
    always @(negedge mclk) begin
        if (rtc === 1'b1) begin
            rtc_n++;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 check(what, exp, rdata);
    endtask
    task automatic ticks(input int k, input int n, input int gap);
        repeat (n) begin
            @(posedge mclk);
            tk[k] <= 1'b1;
            @(posedge mclk);
            tk[k] <= 1'b0;
            repeat (gap) @(posedge mclk);
        end
    endtask
    task automatic periph(input logic [31:0] d, input logic [31:0] exp);
        @(posedge mclk);
        psel <= 32'h0000_0001;
        pstart <= 1'b1;
        @(posedge mclk);
        pstart <= 1'b0;
        #1 check("periph_wait", 32'h0000_0001, {31'h0, pwait});
        @(posedge mclk);
        pdone <= 1'b1;
        pdata <= d;
        @(posedge mclk);
        pdone <= 1'b0;
        pdata <= ~d;
        #1 check("periph_rdata_gated", exp, pgated);
    endtask
    task automatic t_gates();
        int pos[13] = '{0, 1, 2, 11, 14, 17, 18, 21, 22, 23, 25, 27, 28};
        rd("gates reset", GATES_OFFSET, 32'h0000_0000);
        rd("unmapped", 8'h40, 32'h0000_0000);
        for (int i = 0; i < 13; i++) begin
            wr(GATES_OFFSET, 32'h0000_0001 << pos[i], 4'hf);
            #1 check("one enable", 32'h0000_0001 << i, {19'h0, en});
        end
        wr(GATES_OFFSET, 32'hffff_ffff, 4'hf);
        rd("gates all", GATES_OFFSET, 32'h1ae6_4807);
        wr(GATES_OFFSET, 32'h0000_0000, 4'h1);
        wr(GATES_OFFSET, 32'h0000_0000, 4'hc);
        wr(8'h40, 32'h0000_0000, 4'hf);
        rd("gates lanes", GATES_OFFSET, 32'h0000_4800);
    endtask
    task automatic t_periph();
        periph(32'ha5a5_5a5a, 32'h0000_0000);
        wr(GATES_OFFSET, 32'h0000_0001, 4'hf);
        periph(32'ha5a5_5a5a, 32'ha5a5_5a5a);
    endtask
    task automatic t_backup();
        rd("backup reset", BACKUP_OFFSET, 32'h0000_0000);
        wr(BACKUP_OFFSET, 32'h0000_8105, 4'hf);
        rd("locked", BACKUP_OFFSET, 32'h0000_0000);
        unlock <= 1'b1;
        wr(BACKUP_OFFSET, 32'h0000_8105, 4'hf);
        rd("unlocked", BACKUP_OFFSET, 32'h0000_8105);
        check("osc pins", 32'h0000_0003, {30'h0, osc_on, osc_byp});
        wr(BACKUP_OFFSET, 32'h0000_8205, 4'hf);
        rd("source kept", BACKUP_OFFSET, 32'h0000_8105);
        ticks(0, 4, 2);
        rd("stable", BACKUP_OFFSET, 32'h0000_8107);
        rtc_n = 0;
        ticks(0, 4, 2);
        check("slow ext rtc", 32'd4, rtc_n);
        repeat (30) @(posedge mclk);
        rd("unstable", BACKUP_OFFSET, 32'h0000_8105);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        rd("sys reset kept", BACKUP_OFFSET, 32'h0000_8105);
        rd("sys reset gates", GATES_OFFSET, 32'h0000_0000);
        wr(BACKUP_OFFSET, 32'h0001_0000, 4'hf);
        #1 check("soft reset", 32'h0000_0001, {31'h0, bd_rst});
        rd("soft held", BACKUP_OFFSET, 32'h0001_0000);
        wr(BACKUP_OFFSET, 32'h0000_0000, 4'hf);
        #1 check("soft off", 32'h0000_0000, {31'h0, bd_rst});
        wr(BACKUP_OFFSET, 32'h0000_8305, 4'hf);
        rtc_n = 0;
        ticks(2, 256, 1);
        check("fast rtc", 32'd2, rtc_n);
        bk_rstn <= 1'b0;
        @(posedge mclk);
        bk_rstn <= 1'b1;
        rd("domain reset", BACKUP_OFFSET, 32'h0000_0000);
        wr(BACKUP_OFFSET, 32'h0000_8200, 4'hf);
        rtc_n = 0;
        ticks(1, 3, 1);
        check("slow int rtc", 32'd3, rtc_n);
        wr(BACKUP_OFFSET, 32'h0000_0200, 4'hf);
        rtc_n = 0;
        ticks(1, 3, 1);
        check("rtc off", 32'd0, rtc_n);
    endtask
    task automatic t_wait();
        @(posedge mclk);
        addr <= BACKUP_OFFSET;
        rd_s <= 1'b1;
        #1 check("lone wait", 32'h0000_0000, {31'h0, bwait});
        @(posedge mclk);
        #1 check("repeat wait", 32'h0000_0001, {31'h0, bwait});
        @(posedge mclk);
        rd_s <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Run limit
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        $display("[ERR] run limit expected end seen hang");
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        bk_rstn <= 1'b1;
        t_gates();
        t_periph();
        t_backup();
        t_wait();
        tally_and_finish();
    end
endmodule
`default_nettype wire
